// ===== core/pdma_channel_pair.sv
/*
 * Receive and transmit DMA channel pair with buffer chaining and a
 * receive-first, oldest-first request arbiter. Assumes the peripheral
 * ready lines may be asynchronous to clock and that the system bus answers
 * each access with a one-cycle done pulse after grant.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps

// Behaviour
// - Writing the current counter while active adopts the new count at once.
// - Current counter at zero loads next pointer and counter, keeping trigger on.
// - Each channel flags end of buffer and end of both buffers.
// - Writing a channel's counter or next counter clears its end flags.
// - Chaining a buffer clears the next counter in the same cycle.
// - Transfers start only on the peripheral ready requests.
// - Receive: get bus, read holding register, then write memory at pointer.
// - After each transfer advance pointer and decrement counter.
// - Whole block done: signal peripheral and stop transfers.
// - Transmit: read memory at pointer, then write peripheral transmit register.
// - Simultaneous same-direction requests go by peripheral number.
// - Non-simultaneous requests are served in arrival order.
// - Receive requests are served before simultaneous transmit requests.
// - Ten registers from offset 0x100; readable ones reset to zero. Code adds an eleventh, size at 0x128.
// - Receive counter in low sixteen bits at 0x104, readable any time.
// - Receive pointer holds full 32-bit address and tracks advancement.
// - Control at 0x120 is write-only; status at 0x124 read-only, reset zero.
// - Pointer steps by 1, 2 or 4 for byte, half-word, word.
// - Both-buffers flag only when current and next counters are zero.
// - Next counter zero at expiry disables trigger and sets end flag.
// - Disable bit beats enable bit in the same write.
module pdma_channel_pair
   import pdma_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          arst_n,
   input  wire pdma_reg_req_s reg_req,
   output logic [31:0]        reg_rdata,
   input  wire logic          rx_ready_request,
   input  wire logic          tx_ready_request,
   output pdma_bus_req_s      bus_req,
   input  wire logic          bus_grant,
   input  wire logic          bus_done,
   input  wire logic [31:0]   bus_rdata,
   output pdma_flags_s        flags,
   output logic               rx_transfer_on,
   output logic               tx_transfer_on
);

   typedef enum logic [1:0] {
      PDMA_ST_IDLE,
      PDMA_ST_READ,
      PDMA_ST_WRITE,
      PDMA_ST_UPDATE
   } pdma_state_e;

   pdma_state_e   state_ff;
   pdma_dir_e     dir_ff;
   logic [31:0]   rx_ptr_ff, tx_ptr_ff, rx_nptr_ff, tx_nptr_ff;
   logic [15:0]   rx_cnt_ff, tx_cnt_ff, rx_ncnt_ff, tx_ncnt_ff;
   logic          rx_on_ff, tx_on_ff;
   logic [1:0]    size_ff;
   logic [31:0]   data_ff;
   logic [31:0]   rdata_ff;
   pdma_bus_req_s bus_ff;
   pdma_flags_s   flags_ff;
   logic          rx_pend_ff, tx_pend_ff;
   logic          tx_older_ff;
   logic          rx_settle_ff, tx_settle_ff;
   logic          rx_sync1_ff, rx_sync2_ff, tx_sync1_ff, tx_sync2_ff;

   logic          wr_rx_cnt, wr_tx_cnt, wr_rx_ncnt, wr_tx_ncnt, wr_ctrl;
   logic          rx_done, tx_done;
   logic [31:0]   step;
   logic          rx_elig, tx_elig;
   logic [31:0]   nxt_rdata;

   // Ready lines come from a peripheral possibly outside this clock tree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_sync1_ff <= 1'b0;
         rx_sync2_ff <= 1'b0;
         tx_sync1_ff <= 1'b0;
         tx_sync2_ff <= 1'b0;
      end else begin
         rx_sync1_ff <= rx_ready_request;
         rx_sync2_ff <= rx_sync1_ff;
         tx_sync1_ff <= tx_ready_request;
         tx_sync2_ff <= tx_sync1_ff;
      end
   end

   assign wr_rx_cnt  = reg_req.wr && reg_req.addr == PDMA_OFF_RX_CNT;
   assign wr_tx_cnt  = reg_req.wr && reg_req.addr == PDMA_OFF_TX_CNT;
   assign wr_rx_ncnt = reg_req.wr && reg_req.addr == PDMA_OFF_RX_NCNT;
   assign wr_tx_ncnt = reg_req.wr && reg_req.addr == PDMA_OFF_TX_NCNT;
   assign wr_ctrl    = reg_req.wr && reg_req.addr == PDMA_OFF_CTRL;

   // Completion of one datum, seen in the update state
   assign rx_done = state_ff == PDMA_ST_UPDATE && dir_ff == PDMA_DIR_RX;
   assign tx_done = state_ff == PDMA_ST_UPDATE && dir_ff == PDMA_DIR_TX;

   // Pointer step from transfer size
   always_comb begin
      unique case (size_ff)
         PDMA_SZ_BYTE: step = 32'h0000_0001;
         PDMA_SZ_HALF: step = 32'h0000_0002;
         default:      step = 32'h0000_0004;
      endcase
   end

   // Channel eligibility: enabled, requested, nonzero count
   assign rx_elig = rx_on_ff && rx_pend_ff && rx_cnt_ff != 16'h0000;
   assign tx_elig = tx_on_ff && tx_pend_ff && tx_cnt_ff != 16'h0000;

   // Pending requests with arrival order; a request drops once served
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_pend_ff  <= 1'b0;
         tx_pend_ff  <= 1'b0;
         tx_older_ff <= 1'b0;
         rx_settle_ff <= 1'b0;
         tx_settle_ff <= 1'b0;
      end else begin
         // Synchroniser still shows a consumed request one cycle past update
         rx_settle_ff <= rx_done;
         tx_settle_ff <= tx_done;
         rx_pend_ff <= rx_sync2_ff && !rx_settle_ff &&
                       !(rx_done || (state_ff != PDMA_ST_IDLE && dir_ff == PDMA_DIR_RX));
         tx_pend_ff <= tx_sync2_ff && !tx_settle_ff &&
                       !(tx_done || (state_ff != PDMA_ST_IDLE && dir_ff == PDMA_DIR_TX));
         // Transmit raised strictly before receive keeps its turn
         if (tx_pend_ff && !rx_pend_ff && rx_sync2_ff)
            tx_older_ff <= 1'b1;
         else if (!tx_pend_ff || !rx_pend_ff)
            tx_older_ff <= 1'b0;
      end
   end

   // Transfer sequencer; one peripheral per pair, so ordering is trivial
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= PDMA_ST_IDLE;
         dir_ff   <= PDMA_DIR_NONE;
         data_ff  <= 32'h0000_0000;
         bus_ff   <= '0;
      end else begin
         unique case (state_ff)
            PDMA_ST_IDLE: begin
               bus_ff.req <= 1'b0;
               if (rx_elig && !(tx_elig && tx_older_ff)) begin
                  dir_ff   <= PDMA_DIR_RX;
                  state_ff <= PDMA_ST_READ;
                  bus_ff   <= '{req: 1'b1, write: 1'b0, periph: 1'b1, addr: 32'h0, wdata: 32'h0,
                                size: size_ff};
               end else if (tx_elig) begin
                  dir_ff   <= PDMA_DIR_TX;
                  state_ff <= PDMA_ST_READ;
                  bus_ff   <= '{req: 1'b1, write: 1'b0, periph: 1'b0, addr: tx_ptr_ff, wdata: 32'h0,
                                size: size_ff};
               end
            end
            PDMA_ST_READ: begin
               if (bus_grant && bus_done) begin
                  data_ff      <= bus_rdata;
                  state_ff     <= PDMA_ST_WRITE;
                  bus_ff.write <= 1'b1;
                  bus_ff.wdata <= bus_rdata;
                  bus_ff.periph <= dir_ff == PDMA_DIR_TX;
                  bus_ff.addr  <= dir_ff == PDMA_DIR_RX ? rx_ptr_ff : 32'h0;
               end
            end
            PDMA_ST_WRITE: begin
               if (bus_grant && bus_done) begin
                  bus_ff.req <= 1'b0;
                  state_ff   <= PDMA_ST_UPDATE;
               end
            end
            PDMA_ST_UPDATE: begin
               state_ff <= PDMA_ST_IDLE;
               dir_ff   <= PDMA_DIR_NONE;
            end
            default: state_ff <= PDMA_ST_IDLE;
         endcase
      end
   end

   // Receive pointer and counters
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_ptr_ff  <= PDMA_RST_PTR;
         rx_cnt_ff  <= PDMA_RST_CNT;
         rx_nptr_ff <= PDMA_RST_PTR;
         rx_ncnt_ff <= PDMA_RST_CNT;
      end else begin
         if (rx_done && rx_cnt_ff == 16'h0001 && rx_ncnt_ff != 16'h0000) begin
            rx_ptr_ff  <= rx_nptr_ff;
            rx_cnt_ff  <= rx_ncnt_ff;
            rx_ncnt_ff <= PDMA_RST_CNT;
         end else if (rx_done) begin
            rx_ptr_ff <= rx_ptr_ff + step;
            rx_cnt_ff <= rx_cnt_ff - 16'h0001;
         end
         // Software writes win over the update in the same cycle
         if (reg_req.wr && reg_req.addr == PDMA_OFF_RX_PTR) rx_ptr_ff <= reg_req.wdata;
         if (wr_rx_cnt) rx_cnt_ff <= reg_req.wdata[15:0];
         if (reg_req.wr && reg_req.addr == PDMA_OFF_RX_NPTR) rx_nptr_ff <= reg_req.wdata;
         if (wr_rx_ncnt) rx_ncnt_ff <= reg_req.wdata[15:0];
      end
   end

   // Transmit pointer and counters
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_ptr_ff  <= PDMA_RST_PTR;
         tx_cnt_ff  <= PDMA_RST_CNT;
         tx_nptr_ff <= PDMA_RST_PTR;
         tx_ncnt_ff <= PDMA_RST_CNT;
      end else begin
         if (tx_done && tx_cnt_ff == 16'h0001 && tx_ncnt_ff != 16'h0000) begin
            tx_ptr_ff  <= tx_nptr_ff;
            tx_cnt_ff  <= tx_ncnt_ff;
            tx_ncnt_ff <= PDMA_RST_CNT;
         end else if (tx_done) begin
            tx_ptr_ff <= tx_ptr_ff + step;
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
         end
         if (reg_req.wr && reg_req.addr == PDMA_OFF_TX_PTR) tx_ptr_ff <= reg_req.wdata;
         if (wr_tx_cnt) tx_cnt_ff <= reg_req.wdata[15:0];
         if (reg_req.wr && reg_req.addr == PDMA_OFF_TX_NPTR) tx_nptr_ff <= reg_req.wdata;
         if (wr_tx_ncnt) tx_ncnt_ff <= reg_req.wdata[15:0];
      end
   end

   // Enables: disable wins; expiry with empty next buffer drops the trigger
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_on_ff <= 1'b0;
         tx_on_ff <= 1'b0;
      end else begin
         if (wr_ctrl && reg_req.wdata[PDMA_BIT_RX_OFF])
            rx_on_ff <= 1'b0;
         else if (wr_ctrl && reg_req.wdata[PDMA_BIT_RX_ON])
            rx_on_ff <= 1'b1;
         else if (rx_done && rx_cnt_ff == 16'h0001 && rx_ncnt_ff == 16'h0000)
            rx_on_ff <= 1'b0;
         if (wr_ctrl && reg_req.wdata[PDMA_BIT_TX_OFF])
            tx_on_ff <= 1'b0;
         else if (wr_ctrl && reg_req.wdata[PDMA_BIT_TX_ON])
            tx_on_ff <= 1'b1;
         else if (tx_done && tx_cnt_ff == 16'h0001 && tx_ncnt_ff == 16'h0000)
            tx_on_ff <= 1'b0;
      end
   end

   // Transfer size, own register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         size_ff <= PDMA_RST_SIZE;
      else if (reg_req.wr && reg_req.addr == PDMA_OFF_SIZE)
         size_ff <= reg_req.wdata[1:0];
   end

   // End flags; a counter write clears them but completion in the same cycle wins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flags_ff <= '0;
      end else begin
         if (rx_done && rx_cnt_ff == 16'h0001)
            flags_ff.rx_buffer_end_flag <= 1'b1;
         else if (wr_rx_cnt || wr_rx_ncnt)
            flags_ff.rx_buffer_end_flag <= 1'b0;
         if (rx_done && rx_cnt_ff == 16'h0001 && rx_ncnt_ff == 16'h0000)
            flags_ff.rx_both_buffers_full <= 1'b1;
         else if (wr_rx_cnt || wr_rx_ncnt)
            flags_ff.rx_both_buffers_full <= 1'b0;
         if (tx_done && tx_cnt_ff == 16'h0001)
            flags_ff.tx_buffer_end_flag <= 1'b1;
         else if (wr_tx_cnt || wr_tx_ncnt)
            flags_ff.tx_buffer_end_flag <= 1'b0;
         if (tx_done && tx_cnt_ff == 16'h0001 && tx_ncnt_ff == 16'h0000)
            flags_ff.tx_both_buffers_empty <= 1'b1;
         else if (wr_tx_cnt || wr_tx_ncnt)
            flags_ff.tx_both_buffers_empty <= 1'b0;
      end
   end

   // Read mux; control is write-only and unmapped addresses read zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (reg_req.addr)
         PDMA_OFF_RX_PTR:  nxt_rdata = rx_ptr_ff;
         PDMA_OFF_RX_CNT:  nxt_rdata = {16'h0000, rx_cnt_ff};
         PDMA_OFF_TX_PTR:  nxt_rdata = tx_ptr_ff;
         PDMA_OFF_TX_CNT:  nxt_rdata = {16'h0000, tx_cnt_ff};
         PDMA_OFF_RX_NPTR: nxt_rdata = rx_nptr_ff;
         PDMA_OFF_RX_NCNT: nxt_rdata = {16'h0000, rx_ncnt_ff};
         PDMA_OFF_TX_NPTR: nxt_rdata = tx_nptr_ff;
         PDMA_OFF_TX_NCNT: nxt_rdata = {16'h0000, tx_ncnt_ff};
         PDMA_OFF_STATUS:  nxt_rdata = {23'h0, tx_on_ff, 7'h0, rx_on_ff};
         PDMA_OFF_SIZE:    nxt_rdata = {30'h0, size_ff};
         default:          nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         rdata_ff <= 32'h0000_0000;
      else if (reg_req.rd)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= 32'h0000_0000;
   end

   assign reg_rdata      = rdata_ff;
   assign bus_req        = bus_ff;
   assign flags          = flags_ff;
   assign rx_transfer_on = rx_on_ff;
   assign tx_transfer_on = tx_on_ff;

   a_chain_clears_next: assert property (@(posedge clock) disable iff (!arst_n)
      rx_done && rx_cnt_ff == 16'h0001 && rx_ncnt_ff != 16'h0000 && !reg_req.wr
      |=> rx_ncnt_ff == 16'h0000 && rx_cnt_ff == $past(rx_ncnt_ff))
      else $error("next counter not moved on chaining");

   a_step_pointer: assert property (@(posedge clock) disable iff (!arst_n)
      rx_done && rx_cnt_ff > 16'h0001 && !reg_req.wr |=> rx_ptr_ff == $past(rx_ptr_ff) + $past(step))
      else $error("receive pointer step wrong");

   a_counter_write: assert property (@(posedge clock) disable iff (!arst_n)
      wr_rx_cnt |=> rx_cnt_ff == $past(reg_req.wdata[15:0]))
      else $error("counter write not adopted");

   a_flag_clear: assert property (@(posedge clock) disable iff (!arst_n)
      wr_tx_ncnt && !tx_done |=> !flags_ff.tx_buffer_end_flag)
      else $error("end flag not cleared");

   a_disable_wins: assert property (@(posedge clock) disable iff (!arst_n)
      wr_ctrl && reg_req.wdata[PDMA_BIT_RX_OFF] |=> !rx_on_ff)
      else $error("disable lost to enable");

   a_zero_no_xfer: assert property (@(posedge clock) disable iff (!arst_n)
      state_ff == PDMA_ST_IDLE && rx_cnt_ff == 16'h0000 && tx_cnt_ff == 16'h0000 |=> !bus_ff.req)
      else $error("transfer with zero count");

   a_rx_first: assert property (@(posedge clock) disable iff (!arst_n)
      state_ff == PDMA_ST_IDLE && rx_elig && tx_elig && !tx_older_ff |=> dir_ff == PDMA_DIR_RX)
      else $error("transmit served before receive");

   a_both_flag: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(flags_ff.rx_both_buffers_full) |-> rx_cnt_ff == 16'h0000 && rx_ncnt_ff == 16'h0000 && !rx_on_ff)
      else $error("both-buffers flag with counts left");

   a_rx_sequence: assert property (@(posedge clock) disable iff (!arst_n)
      state_ff == PDMA_ST_IDLE ##1 state_ff == PDMA_ST_READ && dir_ff == PDMA_DIR_RX
      |-> bus_ff.periph && !bus_ff.write)
      else $error("receive did not start at peripheral");

   sequence s_tx_quiet;
      !tx_pend_ff ##1 !tx_pend_ff;
   endsequence

   a_pend_settle: assert property (@(posedge clock) disable iff (!arst_n)
      tx_done |=> s_tx_quiet)
      else $error("consumed transmit request served again");

   a_ctrl_reads_zero: assert property (@(posedge clock) disable iff (!arst_n)
      reg_req.rd && reg_req.addr == PDMA_OFF_CTRL |=> reg_rdata == 32'h0000_0000)
      else $error("control register readable");

   a_tx_both_flag: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(flags_ff.tx_both_buffers_empty) |-> tx_cnt_ff == 16'h0000 && tx_ncnt_ff == 16'h0000)
      else $error("transmit both-buffers flag with counts left");

   a_no_unasked_start: assert property (@(posedge clock) disable iff (!arst_n)
      state_ff == PDMA_ST_IDLE && !rx_elig && !tx_elig |=> state_ff == PDMA_ST_IDLE)
      else $error("transfer started without request");

endmodule

// ===== core/pdma_pkg.sv
/*
 * Constants and carrier types for the peripheral DMA channel pair.
 * Assumes a single 125 MHz clock domain and a simple register port.
 */
package pdma_pkg;

   // Register byte offsets
   localparam logic [11:0] PDMA_OFF_RX_PTR   = 12'h100;
   localparam logic [11:0] PDMA_OFF_RX_CNT   = 12'h104;
   localparam logic [11:0] PDMA_OFF_TX_PTR   = 12'h108;
   localparam logic [11:0] PDMA_OFF_TX_CNT   = 12'h10c;
   localparam logic [11:0] PDMA_OFF_RX_NPTR  = 12'h110;
   localparam logic [11:0] PDMA_OFF_RX_NCNT  = 12'h114;
   localparam logic [11:0] PDMA_OFF_TX_NPTR  = 12'h118;
   localparam logic [11:0] PDMA_OFF_TX_NCNT  = 12'h11c;
   localparam logic [11:0] PDMA_OFF_CTRL     = 12'h120;
   localparam logic [11:0] PDMA_OFF_STATUS   = 12'h124;
   // Own choice: transfer size register (0 byte, 1 half-word, 2 word)
   localparam logic [11:0] PDMA_OFF_SIZE     = 12'h128;

   // Field positions
   localparam int PDMA_BIT_RX_ON  = 0;
   localparam int PDMA_BIT_RX_OFF = 1;
   localparam int PDMA_BIT_TX_ON  = 8;
   localparam int PDMA_BIT_TX_OFF = 9;

   // Reset values
   localparam logic [31:0] PDMA_RST_PTR  = 32'h0000_0000;
   localparam logic [15:0] PDMA_RST_CNT  = 16'h0000;
   localparam logic [1:0]  PDMA_RST_SIZE = 2'h0;

   // Size codes
   localparam logic [1:0] PDMA_SZ_BYTE = 2'h0;
   localparam logic [1:0] PDMA_SZ_HALF = 2'h1;

   typedef enum logic [1:0] {
      PDMA_DIR_NONE,
      PDMA_DIR_RX,
      PDMA_DIR_TX
   } pdma_dir_e;

   // Host register port
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pdma_reg_req_s;

   // System bus request
   typedef struct packed {
      logic        req;
      logic        write;
      logic        periph;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  size;
   } pdma_bus_req_s;

   // Flags presented to the peripheral status register
   typedef struct packed {
      logic rx_buffer_end_flag;
      logic tx_buffer_end_flag;
      logic rx_both_buffers_full;
      logic tx_both_buffers_empty;
   } pdma_flags_s;

endpackage

// ===== verification/pdma_far_model.sv
/*
 * Far-side model: serial peripheral holding registers plus system bus memory.
 * Assumes the channel pair bus protocol, one clock and an active-low reset.
 */
`timescale 1ns/10ps
module pdma_far_model
   import pdma_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          arst_n,
   input  wire pdma_bus_req_s bus_req,
   output logic               bus_grant,
   output logic               bus_done,
   output logic [31:0]        bus_rdata,
   output logic               rx_ready_request,
   output logic               tx_ready_request,
   input  wire logic [3:0]    rx_add,
   input  wire logic [3:0]    tx_add,
   input  wire logic [4:0]    delay
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] tx_q [$];
   logic        kind_q [$];
   int          xfer_cnt;
   logic [1:0]  key_ff;
   logic        served_ff;
   logic [4:0]  wait_ff;
   logic [7:0]  rx_data_ff;
   logic [7:0]  rx_left_ff;
   logic [7:0]  tx_left_ff;
   logic        rx_take;
   logic        tx_take;

   assign bus_grant        = bus_req.req;
   assign rx_take          = bus_done && bus_req.req && !bus_req.write && bus_req.periph;
   assign tx_take          = bus_done && bus_req.req && bus_req.write && bus_req.periph;
   assign rx_ready_request = (rx_left_ff != 8'h00);
   assign tx_ready_request = (tx_left_ff != 8'h00);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         key_ff     <= 2'h0;
         served_ff  <= 1'b0;
         wait_ff    <= 5'h00;
         bus_done   <= 1'b0;
         bus_rdata  <= 32'h0000_0000;
         rx_data_ff <= 8'h40;
         rx_left_ff <= 8'h00;
         tx_left_ff <= 8'h00;
      end else begin
         key_ff     <= {bus_req.req, bus_req.write};
         bus_done   <= 1'b0;
         // Released data lines never keep the last value
         bus_rdata  <= ~bus_rdata;
         rx_left_ff <= rx_left_ff + 8'(rx_add) - 8'(rx_take);
         tx_left_ff <= tx_left_ff + 8'(tx_add) - 8'(tx_take);
         if (rx_take) begin
            rx_data_ff <= rx_data_ff + 8'h01;
         end
         if ({bus_req.req, bus_req.write} != key_ff) begin
            wait_ff   <= 5'h00;
            served_ff <= 1'b0;
         end else if (bus_req.req && !served_ff) begin
            if (wait_ff == delay) begin
               bus_done  <= 1'b1;
               served_ff <= 1'b1;
               if (!bus_req.write) begin
                  bus_rdata <= bus_req.periph ? {24'h0, rx_data_ff} : (bus_req.addr ^ 32'h5a5a_5a5a);
               end
            end else begin
               wait_ff <= wait_ff + 5'h01;
            end
         end
      end
   end

   // Log of completed accesses for the bench
   always @(posedge clock) begin
      if (arst_n && bus_done && bus_req.req) begin
         if (rx_take) begin
            kind_q.push_back(1'b0);
         end
         if (bus_req.write) begin
            xfer_cnt++;
            if (bus_req.periph) begin
               tx_q.push_back(bus_req.wdata);
               kind_q.push_back(1'b1);
            end else begin
               mem[bus_req.addr] = bus_req.wdata;
            end
         end
      end
   end
endmodule

// ===== verification/tb.sv
/*
 * Self-checking bench for the DMA channel pair: register tasks and tests.
 * Assumes the far-side model answers the bus and plays the peripheral.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb
   import pdma_pkg::*;
;
   logic          clock;
   logic          arst_n;
   pdma_reg_req_s reg_req;
   logic [31:0]   reg_rdata;
   pdma_bus_req_s bus_req;
   logic          bus_grant;
   logic          bus_done;
   logic [31:0]   bus_rdata;
   pdma_flags_s   flags;
   logic          rx_ready_request;
   logic          tx_ready_request;
   logic          rx_transfer_on;
   logic          tx_transfer_on;
   logic [3:0]    rx_add;
   logic [3:0]    tx_add;
   logic [4:0]    delay;
   int            fails;
   int            check_count;
   int            xf;
   int            q0;

   pdma_channel_pair dut (.clock(clock), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .rx_ready_request(rx_ready_request), .tx_ready_request(tx_ready_request), .bus_req(bus_req),
      .bus_grant(bus_grant), .bus_done(bus_done), .bus_rdata(bus_rdata), .flags(flags),
      .rx_transfer_on(rx_transfer_on), .tx_transfer_on(tx_transfer_on));
   pdma_far_model far (.clock(clock), .arst_n(arst_n), .bus_req(bus_req), .bus_grant(bus_grant),
      .bus_done(bus_done), .bus_rdata(bus_rdata), .rx_ready_request(rx_ready_request),
      .tx_ready_request(tx_ready_request), .rx_add(rx_add), .tx_add(tx_add), .delay(delay));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic report_and_stop;
      if (fails == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      reg_req <= {a, d, 1'b1, 1'b0};
      @(posedge clock);
      reg_req <= '0;
      @(posedge clock);
   endtask

   task automatic reg_chk(input logic [11:0] a, input logic [31:0] e);
      reg_req <= {a, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
      reg_req <= '0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
      @(posedge clock);
   endtask

   task automatic offer(input logic [3:0] r, input logic [3:0] t);
      rx_add <= r;
      tx_add <= t;
      @(posedge clock);
      rx_add <= 4'h0;
      tx_add <= 4'h0;
      @(posedge clock);
   endtask

   // Bounded wait for the model to log n more completed transfers
   task automatic wait_xfers(input int n);
      int k;
      k = 0;
      xf += n;
      while (far.xfer_cnt < xf && k < 800) begin
         @(posedge clock);
         k++;
      end
      repeat (3) @(posedge clock);
      `CHK("xfer_cnt", xf, far.xfer_cnt)
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      report_and_stop();
   end

   initial begin
      reg_req = '0;
      rx_add = 4'h0;
      tx_add = 4'h0;
      delay = 5'h00;
      arst_n = 1'b0;
      fails = 0;
      check_count = 0;
      xf = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      `CHK("flags", 4'h0, flags)
      for (int a = 'h100; a <= 'h12c; a += 4) reg_chk(12'(a), 32'h0);
      reg_wr(PDMA_OFF_RX_CNT, 32'hffff_0003);
      reg_chk(PDMA_OFF_RX_CNT, 32'h0000_0003);
      reg_wr(PDMA_OFF_STATUS, 32'hffff_ffff);
      reg_chk(PDMA_OFF_STATUS, 32'h0);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0003);
      reg_chk(PDMA_OFF_STATUS, 32'h0);
      // Zero count while enabled, then rewrite the count mid-buffer
      reg_wr(PDMA_OFF_RX_CNT, 32'h0);
      reg_wr(PDMA_OFF_RX_PTR, 32'h1000_0000);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0001);
      reg_chk(PDMA_OFF_STATUS, 32'h1);
      reg_chk(PDMA_OFF_CTRL, 32'h0);
      offer(4'h1, 4'h0);
      repeat (30) @(posedge clock);
      `CHK("xfer_cnt", 0, far.xfer_cnt)
      reg_wr(PDMA_OFF_RX_CNT, 32'h5);
      wait_xfers(1);
      reg_chk(PDMA_OFF_RX_CNT, 32'h4);
      reg_wr(PDMA_OFF_RX_CNT, 32'h2);
      offer(4'h5, 4'h0);
      wait_xfers(2);
      repeat (30) @(posedge clock);
      `CHK("xfer_cnt", 3, far.xfer_cnt)
      reg_chk(PDMA_OFF_RX_CNT, 32'h0);
      reg_chk(PDMA_OFF_RX_PTR, 32'h1000_0003);
      for (int k = 0; k < 3; k++) `CHK("mem", 32'h40 + k, far.mem[32'h1000_0000 + k])
      `CHK("rx_end", 1'b1, flags.rx_buffer_end_flag)
      `CHK("rx_both", 1'b1, flags.rx_both_buffers_full)
      `CHK("rx_on", 1'b0, rx_transfer_on)
      reg_wr(PDMA_OFF_RX_NCNT, 32'h0);
      `CHK("rx_end", 1'b0, flags.rx_buffer_end_flag)
      // Chained half-word buffers; three characters are still waiting
      reg_wr(PDMA_OFF_SIZE, 32'h1);
      reg_wr(PDMA_OFF_RX_PTR, 32'h3000_0000);
      reg_wr(PDMA_OFF_RX_CNT, 32'h2);
      reg_wr(PDMA_OFF_RX_NPTR, 32'h3100_0000);
      reg_wr(PDMA_OFF_RX_NCNT, 32'h2);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0001);
      wait_xfers(3);
      repeat (30) @(posedge clock);
      `CHK("xfer_cnt", xf, far.xfer_cnt)
      reg_chk(PDMA_OFF_RX_PTR, 32'h3100_0002);
      reg_chk(PDMA_OFF_RX_CNT, 32'h1);
      reg_chk(PDMA_OFF_RX_NCNT, 32'h0);
      `CHK("rx_end", 1'b1, flags.rx_buffer_end_flag)
      `CHK("rx_both", 1'b0, flags.rx_both_buffers_full)
      `CHK("rx_on", 1'b1, rx_transfer_on)
      `CHK("mem", 32'h44, far.mem[32'h3000_0002])
      offer(4'h1, 4'h0);
      wait_xfers(1);
      reg_chk(PDMA_OFF_RX_PTR, 32'h3100_0004);
      `CHK("mem", 32'h46, far.mem[32'h3100_0002])
      `CHK("rx_both", 1'b1, flags.rx_both_buffers_full)
      `CHK("rx_on", 1'b0, rx_transfer_on)
      // Word transmit
      reg_wr(PDMA_OFF_SIZE, 32'h2);
      reg_wr(PDMA_OFF_TX_PTR, 32'h2000_0000);
      reg_wr(PDMA_OFF_TX_CNT, 32'h2);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0100);
      offer(4'h0, 4'h2);
      wait_xfers(2);
      `CHK("tx_data", 32'h7a5a_5a5a, far.tx_q[0])
      `CHK("tx_data", 32'h7a5a_5a5e, far.tx_q[1])
      reg_chk(PDMA_OFF_TX_PTR, 32'h2000_0008);
      `CHK("tx_end", 1'b1, flags.tx_buffer_end_flag)
      `CHK("tx_both", 1'b1, flags.tx_both_buffers_empty)
      `CHK("tx_on", 1'b0, tx_transfer_on)
      reg_wr(PDMA_OFF_TX_NCNT, 32'h0);
      `CHK("tx_end", 1'b0, flags.tx_buffer_end_flag)
      // Arbitration: simultaneous, then staggered behind a slow transfer
      reg_wr(PDMA_OFF_RX_CNT, 32'h3);
      reg_wr(PDMA_OFF_TX_CNT, 32'h2);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0101);
      q0 = far.kind_q.size();
      offer(4'h1, 4'h1);
      wait_xfers(2);
      `CHK("order", 1'b0, far.kind_q[q0])
      `CHK("order", 1'b1, far.kind_q[q0 + 1])
      delay <= 5'h14;
      offer(4'h1, 4'h0);
      repeat (6) @(posedge clock);
      offer(4'h0, 4'h1);
      repeat (3) @(posedge clock);
      offer(4'h1, 4'h0);
      wait_xfers(3);
      `CHK("order", 1'b1, far.kind_q[q0 + 3])
      `CHK("order", 1'b0, far.kind_q[q0 + 4])
      // Both requests wait while disabled; the older transmit must go first
      delay <= 5'h00;
      reg_wr(PDMA_OFF_RX_CNT, 32'h1);
      reg_wr(PDMA_OFF_TX_CNT, 32'h1);
      offer(4'h0, 4'h1);
      repeat (6) @(posedge clock);
      offer(4'h1, 4'h0);
      repeat (6) @(posedge clock);
      reg_wr(PDMA_OFF_CTRL, 32'h0000_0101);
      wait_xfers(2);
      `CHK("order", 1'b1, far.kind_q[q0 + 5])
      `CHK("order", 1'b0, far.kind_q[q0 + 6])
      report_and_stop();
   end
endmodule
